// *** rtl/gdl_driver.sv ***
// two-channel gate driver output decision logic
`timescale 1ns/1ps
`include "gdl_map.svh"

module gdl_driver #(
  parameter int unsigned INPUT_SIDE_SUPPLY_DELAY_CYC = `GDL_INPUT_SIDE_SUPPLY_DELAY_CYC,
  parameter int unsigned VDD_DELAY_CYC  = `GDL_VDD_DELAY_CYC
) (
  input  wire logic                 i_clk_sys,
  input  wire logic                 i_rst,
  input  wire logic                 i_chan_a_input,
  input  wire logic                 i_chan_b_input,
  input  wire logic                 i_output_shutdown,
  input  wire logic [1:0]           i_deadtime_select,
  input  wire logic [`GDL_PV_W-1:0] i_deadtime_program_value,
  input  wire logic                 i_input_supply_above_on,
  input  wire logic                 i_input_supply_above_off,
  input  wire logic                 i_chan_a_supply_above_on,
  input  wire logic                 i_chan_a_supply_above_off,
  input  wire logic                 i_chan_b_supply_above_on,
  input  wire logic                 i_chan_b_supply_above_off,
  output logic                      o_chan_a_drive,
  output logic                      o_chan_b_drive,
  output logic                      o_input_supply_ready,
  output logic                      o_chan_a_supply_ready,
  output logic                      o_chan_b_supply_ready
);

  logic [4:0]              s1;
  logic [4:0]              s2;
  logic [4:0]              s3;
  logic [4:0]              flt;
  logic [1:0]              acc;
  logic [1:0]              acc_d;
  logic [1:0]              drive;
  logic [1:0]              next_drive;
  logic [1:0]              sup_ready;
  logic [`GDL_PV_W-1:0]    pv1;
  logic [`GDL_PV_W-1:0]    pv2;
  logic [`GDL_PV_W-1:0]    pv3;
  logic [`GDL_PV_W-1:0]    pv;
  logic [`GDL_DT_W-1:0]    dt_cnt [2];
  logic [`GDL_DT_W-1:0]    dt_len;
  logic                    shut;
  logic                    overlap;
  gdl_pkg::gdl_dt_mode_e   mode;

  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);

  // dead time length in clock cycles for the selected mode
  function automatic logic [`GDL_DT_W-1:0] dt_cycles(
    input gdl_pkg::gdl_dt_mode_e m,
    input logic [`GDL_PV_W-1:0]  v
  );
    logic [19:0] ns;
    ns = 20'(v) * 20'(`GDL_DT_NS_PER_KOHM);
    case (m)
      gdl_pkg::GDL_DT_RES:     dt_cycles = `GDL_DT_W'(ns / 20'(`GDL_CLK_NS));
      gdl_pkg::GDL_DT_OVERLAP: dt_cycles = '0;
      default:                 dt_cycles = `GDL_DT_W'(`GDL_DT_OPEN_CYC);
    endcase
  endfunction

  gdl_supply_undervoltage_lockout #(.DELAY_CYC(INPUT_SIDE_SUPPLY_DELAY_CYC)) u_input_side_supply (
    .i_clk_sys   (i_clk_sys),
    .i_rst       (i_rst),
    .i_above_on  (i_input_supply_above_on),
    .i_above_off (i_input_supply_above_off),
    .o_good      (),
    .o_ready     (o_input_supply_ready)
  );

  gdl_supply_undervoltage_lockout #(.DELAY_CYC(VDD_DELAY_CYC)) u_chan_a_output_supply (
    .i_clk_sys   (i_clk_sys),
    .i_rst       (i_rst),
    .i_above_on  (i_chan_a_supply_above_on),
    .i_above_off (i_chan_a_supply_above_off),
    .o_good      (),
    .o_ready     (o_chan_a_supply_ready)
  );

  gdl_supply_undervoltage_lockout #(.DELAY_CYC(VDD_DELAY_CYC)) u_chan_b_output_supply (
    .i_clk_sys   (i_clk_sys),
    .i_rst       (i_rst),
    .i_above_on  (i_chan_b_supply_above_on),
    .i_above_off (i_chan_b_supply_above_off),
    .o_good      (),
    .o_ready     (o_chan_b_supply_ready)
  );

  assign sup_ready = {o_chan_b_supply_ready, o_chan_a_supply_ready};

  // pins cross in through three stages; reset value low covers open inputs
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      s1 <= 5'h00;
      s2 <= 5'h00;
      s3 <= 5'h00;
    end else begin
      s1 <= {i_deadtime_select, i_output_shutdown,
             i_chan_b_input, i_chan_a_input};
      s2 <= s1;
      s3 <= s2;
    end
  end

  // strap crosses like the pins; a value counts once two stages agree
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      pv1 <= '0;
      pv2 <= '0;
      pv3 <= '0;
      pv  <= '0;
    end else begin
      pv1 <= i_deadtime_program_value;
      pv2 <= pv1;
      pv3 <= pv2;
      if (pv2 == pv3) begin
        pv <= pv3;
      end
    end
  end

  genvar g;
  generate
    for (g = 0; g < 5; g++) begin : g_flt
      always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
          flt[g] <= 1'b0;
        end else if (s2[g] == s3[g]) begin
          flt[g] <= s3[g];
        end
      end
    end
  endgenerate

  assign shut    = flt[2];
  assign mode    = gdl_pkg::gdl_dt_mode_e'(flt[4:3]);
  assign overlap = (mode == gdl_pkg::GDL_DT_OVERLAP);
  assign dt_len  = dt_cycles(mode, pv);

  generate
    for (g = 0; g < 2; g++) begin : g_chan
      logic [`GDL_PCNT_W-1:0] pcnt;

      // input must hold its new level for the minimum width
      always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
          acc[g] <= 1'b0;
          pcnt   <= '0;
        end else if (flt[g] == acc[g]) begin
          pcnt <= '0;
        end else if (pcnt + 1'b1 >= `GDL_PCNT_W'(`GDL_PULSE_MIN_CYC)) begin
          acc[g] <= flt[g];
          pcnt   <= '0;
        end else begin
          pcnt <= pcnt + 1'b1;
        end
      end

      always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
          acc_d[g] <= 1'b0;
        end else begin
          acc_d[g] <= acc[g];
        end
      end

      // a gap already longer than the dead time finds the counter at zero
      always_ff @(posedge i_clk_sys) begin
        if (i_rst || overlap) begin
          dt_cnt[g] <= '0;
        end else if (acc_d[1-g] && !acc[1-g]) begin
          dt_cnt[g] <= dt_len;
        end else if (dt_cnt[g] != '0) begin
          dt_cnt[g] <= dt_cnt[g] - 1'b1;
        end
      end

      always_comb begin
        next_drive[g] = 1'b0;
        if (o_input_supply_ready && sup_ready[g] && !shut) begin
          if (overlap) begin
            next_drive[g] = acc[g];
          end else begin
            // both high gives both low; wait for other drive and dead time
            // a fresh fall loads the dead counter only on the next edge
            next_drive[g] = acc[g] && !acc[1-g] && !drive[1-g]
                            && !acc_d[1-g]
                            && dt_cnt[g] == '0;
          end
        end
      end

      always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
          drive[g] <= `GDL_RST_DRIVE;
        end else begin
          drive[g] <= next_drive[g];
        end
      end
    end
  endgenerate

  assign o_chan_a_drive = drive[0];
  assign o_chan_b_drive = drive[1];

  sequence b_fell_with_dt;
    acc_d[1] && !acc[1] && !overlap && dt_len >= `GDL_DT_W'(2);
  endsequence

  sequence a_held_low2;
    !drive[0] ##1 !drive[0];
  endsequence

  input_side_supply_gate_a: assert property (!o_input_supply_ready |=>
      !drive[0] && !drive[1])
    else $error("drive high without input supply ready");
  supply_gate_a: assert property (!o_chan_b_supply_ready |=> !drive[1])
    else $error("channel b driven without its supply");
  shutdown_a: assert property (shut |=> !drive[0] && !drive[1])
    else $error("drive high during shutdown");
  shoot_thru_a: assert property (acc == 2'h3 && !overlap |=>
      !drive[0] && !drive[1])
    else $error("both drives high outside overlap mode");
  overlap_pass_a: assert property (overlap && acc == 2'h3 && !shut
      && o_input_supply_ready && sup_ready == 2'h3 |=> drive == 2'h3)
    else $error("overlap mode did not pass both inputs");
  follow_a: assert property (o_input_supply_ready
      && o_chan_a_supply_ready && !shut && acc[0] && !acc[1] && !acc_d[1]
      && !drive[1] && dt_cnt[0] == '0 |=> drive[0])
    else $error("channel a failed to follow its input");
  dead_wait_a: assert property (b_fell_with_dt |=> a_held_low2)
    else $error("channel a rose inside dead time");

endmodule

// *** common/gdl_map.svh ***
// constants for the dual gate driver output logic
`ifndef GDL_MAP_SVH
`define GDL_MAP_SVH

`define GDL_CLK_NS          10
`define GDL_INPUT_SIDE_SUPPLY_DELAY_US   40
`define GDL_VDD_DELAY_US    50
`define GDL_INPUT_SIDE_SUPPLY_DELAY_CYC  ((`GDL_INPUT_SIDE_SUPPLY_DELAY_US * 1000 + `GDL_CLK_NS - 1) / `GDL_CLK_NS)
`define GDL_VDD_DELAY_CYC   ((`GDL_VDD_DELAY_US * 1000 + `GDL_CLK_NS - 1) / `GDL_CLK_NS)
`define GDL_DT_OPEN_NS      8
`define GDL_DT_OPEN_CYC     ((`GDL_DT_OPEN_NS + `GDL_CLK_NS - 1) / `GDL_CLK_NS)
`define GDL_DT_NS_PER_KOHM  10
`define GDL_PULSE_MIN_NS    5
`define GDL_PULSE_MIN_CYC   ((`GDL_PULSE_MIN_NS + `GDL_CLK_NS - 1) / `GDL_CLK_NS)
`define GDL_CNT_W           13
`define GDL_DT_W            12
`define GDL_PV_W            8
`define GDL_PCNT_W          4
`define GDL_RST_DRIVE       1'b0

`endif

// *** common/gdl_pkg.sv ***
// types for the dual gate driver output logic
package gdl_pkg;

  typedef enum logic [1:0] {
    GDL_DT_OPEN    = 2'h0,
    GDL_DT_RES     = 2'h1,
    GDL_DT_OVERLAP = 2'h2
  } gdl_dt_mode_e;

endpackage

// *** rtl/gdl_supply_undervoltage_lockout.sv ***
// supply good latch with hysteresis and power-up release delay
`timescale 1ns/1ps
`include "gdl_map.svh"

module gdl_supply_undervoltage_lockout #(
  parameter int unsigned DELAY_CYC = 1
) (
  input  wire logic i_clk_sys,
  input  wire logic i_rst,
  input  wire logic i_above_on,
  input  wire logic i_above_off,
  output logic      o_good,
  output logic      o_ready
);

  logic [1:0]           s1;
  logic [1:0]           s2;
  logic [1:0]           s3;
  logic [1:0]           flt;
  logic [`GDL_CNT_W-1:0] cnt;

  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      s1 <= 2'h0;
      s2 <= 2'h0;
      s3 <= 2'h0;
    end else begin
      s1 <= {i_above_off, i_above_on};
      s2 <= s1;
      s3 <= s2;
    end
  end

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_flt
      always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
          flt[g] <= 1'b0;
        end else if (s2[g] == s3[g]) begin
          flt[g] <= s3[g];
        end
      end
    end
  endgenerate

  // set on the upper threshold, clear only below the lower one
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      o_good <= 1'b0;
    end else if (!flt[1]) begin
      o_good <= 1'b0;
    end else if (flt[0]) begin
      o_good <= 1'b1;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    // a drop clears ready with good, so ready never rises on a falling supply
    if (i_rst || !o_good || !flt[1]) begin
      cnt     <= '0;
      o_ready <= 1'b0;
    end else if (!o_ready) begin
      if (cnt == `GDL_CNT_W'(DELAY_CYC - 1)) begin
        o_ready <= 1'b1;
      end else begin
        cnt <= cnt + 1'b1;
      end
    end
  end

  sequence supply_drop;
    !flt[1];
  endsequence

  hyst_hold_a: assert property (o_good && flt[1] |=> o_good)
    else $error("supply good lost above lower threshold");
  fast_drop_a: assert property (supply_drop |=> !o_good ##1 !o_ready)
    else $error("ready not removed promptly after supply drop");
  count_restart_a: assert property (!o_good |=> cnt == '0)
    else $error("release counter not restarted");
  release_time_a: assert property ($rose(o_ready) |->
      o_good && cnt == `GDL_CNT_W'(DELAY_CYC - 1))
    else $error("ready released before full delay");

endmodule

// *** testbench/gdl_pwm_ctrl.sv ***
// pwm controller model feeding the driver channel inputs
`timescale 1ns/1ps

module gdl_pwm_ctrl #(
  parameter int unsigned MARGIN = 8,
  parameter int unsigned HALF   = 24,
  parameter int unsigned GAP    = 3
) (
  input  wire logic i_clk_sys,
  input  wire logic i_run,
  input  wire logic i_ready,
  input  wire logic i_man_a,
  input  wire logic i_man_b,
  output logic      o_chan_a,
  output logic      o_chan_b
);
  int unsigned wait_cnt;
  int unsigned ph_cnt;
  logic        go;

  // no pulses until ready has stood a margin past the release delay
  always_ff @(negedge i_clk_sys) begin
    if (!(i_run && i_ready)) begin
      wait_cnt <= 0;
    end else if (wait_cnt < MARGIN) begin
      wait_cnt <= wait_cnt + 1;
    end
    ph_cnt <= (ph_cnt >= 2 * HALF - 1) ? 0 : ph_cnt + 1;
  end

  // short own gap of 3 cycles, still longer than the one-cycle default dead time that the bench's run selects
  always_comb begin
    go       = (wait_cnt == MARGIN);
    o_chan_a = i_run ? go && ph_cnt < HALF - GAP : i_man_a;
    o_chan_b = i_run ? go && ph_cnt >= HALF && ph_cnt < 2 * HALF - GAP
                     : i_man_b;
  end
endmodule

// *** testbench/test_gdl_driver.sv ***
// self-checking bench for the dual gate driver output logic
`timescale 1ns/1ps

module test_gdl_driver;
  logic       clk, rst, sd, run, ma, mb, a, b, da, db, ri, ra, rb;
  logic       vi_on, vi_off, va_on, va_off, vb_on, vb_off, ov, sa, sb;
  logic [1:0] dt;
  logic [7:0] pv;
  int         bad_count, cmp_count, tick;
  // {a, b, shutdown, mode, expected drive a, expected drive b}
  logic [6:0] rows [11] = '{7'h04, 7'h46, 7'h25, 7'h60, 7'h64, 7'h6C,
                            7'h6B, 7'h4A, 7'h78, 7'h54, 7'h21};

  gdl_driver #(.INPUT_SIDE_SUPPLY_DELAY_CYC(20), .VDD_DELAY_CYC(30)) i_dut (
    .i_clk_sys(clk), .i_rst(rst), .i_chan_a_input(a), .i_chan_b_input(b),
    .i_output_shutdown(sd), .i_deadtime_select(dt),
    .i_deadtime_program_value(pv),
    .i_input_supply_above_on(vi_on), .i_input_supply_above_off(vi_off),
    .i_chan_a_supply_above_on(va_on), .i_chan_a_supply_above_off(va_off),
    .i_chan_b_supply_above_on(vb_on), .i_chan_b_supply_above_off(vb_off),
    .o_chan_a_drive(da), .o_chan_b_drive(db), .o_input_supply_ready(ri),
    .o_chan_a_supply_ready(ra), .o_chan_b_supply_ready(rb));

  gdl_pwm_ctrl i_pwm (
    .i_clk_sys(clk), .i_run(run), .i_ready(ri & ra & rb), .i_man_a(ma),
    .i_man_b(mb), .o_chan_a(a), .o_chan_b(b));

  always #5 clk = ~clk;

  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask

  task automatic chk(input logic [1:0] seen, input logic [1:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR %0t: seen %b expected %b", $time, seen, exp);
    end
  endtask

  task automatic summarize;
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // a hang ends the run well past the expected run of about 1190 cycles
  always @(posedge clk) begin
    tick++;
    if (tick == 6000) begin
      bad_count++;
      summarize();
    end
  end

  initial begin
    {clk, sd, run, ma, mb, vi_on, vi_off, va_on, va_off, vb_on, vb_off} = 0;
    {ov, sa, sb} = 0;
    rst = 1;
    dt = 2'h1;
    pv = 8'h08;
    cyc(20);
    chk({da, db}, 2'h0);
    chk({ri, ra}, 2'h0);
    rst = 0;
    ma = 1;
    {vi_off, va_off, vb_off} = 3'h7;
    cyc(40);
    chk({ri, da}, 2'h0);
    {va_on, vb_on} = 2'h3;
    cyc(60);
    chk({ra, da}, 2'h2);
    vi_on = 1;
    cyc(20);
    chk({ri, da}, 2'h0);
    cyc(15);
    chk({ri, da}, 2'h3);
    {vi_on, va_on, vb_on} = 3'h0;
    cyc(20);
    chk({da, db}, 2'h2);
    for (int i = 0; i < 11; i++) begin
      {ma, mb, sd, dt} = rows[i][6:2];
      cyc(30);
      chk({da, db}, rows[i][1:0]);
    end
    dt = 2'h1;
    cyc(30);
    {ma, mb} = 2'h2;
    cyc(8);
    chk({da, db}, 2'h0);
    cyc(12);
    chk({da, db}, 2'h2);
    {ma, mb} = 2'h0;
    cyc(20);
    mb = 1;
    cyc(8);
    chk({da, db}, 2'h1);
    ma = 1;
    cyc(20);
    chk({da, db}, 2'h0);
    mb = 0;
    cyc(9);
    chk({da, db}, 2'h0);
    cyc(11);
    chk({da, db}, 2'h2);
    {ma, mb} = 2'h1;
    cyc(20);
    dt = 2'h0;
    cyc(20);
    {ma, mb} = 2'h2;
    cyc(12);
    chk({da, db}, 2'h2);
    {ma, dt} = 3'h2;
    cyc(20);
    ma = 1;
    cyc(1);
    ma = 0;
    repeat (15) begin
      cyc(1);
      sa |= da;
    end
    chk({sa, db}, 2'h0);
    {ma, sa} = 2'h2;
    cyc(20);
    va_off = 0;
    cyc(8);
    chk({ra, da}, 2'h0);
    {va_on, va_off} = 2'h3;
    cyc(20);
    {va_on, va_off} = 2'h0;
    cyc(4);
    {va_on, va_off} = 2'h3;
    cyc(30);
    chk({ra, da}, 2'h0);
    cyc(15);
    chk({ra, da}, 2'h3);
    {va_on, mb} = 2'h1;
    cyc(20);
    vi_off = 0;
    cyc(8);
    chk({da, db}, 2'h0);
    {vi_on, vi_off} = 2'h3;
    cyc(40);
    chk({da, db}, 2'h3);
    vb_off = 0;
    cyc(8);
    chk({da, db}, 2'h2);
    {vb_on, vb_off, dt, run} = 5'h1F;
    repeat (300) begin
      cyc(1);
      ov |= da & db;
      sa |= da;
      sb |= db;
    end
    chk({sa, sb}, 2'h3);
    chk({ov, 1'b0}, 2'h0);
    rst = 1;
    cyc(3);
    chk({da, db}, 2'h0);
    chk({ri, rb}, 2'h0);
    summarize();
  end
endmodule
